// ===== hw/fcs_pkg.sv
// Package for the flash command sequencer: offsets, command codes, timing.
// Assumes a 16-bit command offset within the flash window and 32-bit data.
package fcs_pkg;
    // ------------------------------------------------------------
    // Command offsets and codes
    // ------------------------------------------------------------
    localparam logic [15:0] FCS_UNLOCK1_ADDR = 16'haaa8;
    localparam logic [15:0] FCS_UNLOCK2_ADDR = 16'h5554;
    localparam logic [7:0] FCS_RESET_LOW = 8'h00;
    localparam logic [7:0] FCS_UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] FCS_UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] FCS_CMD_RESET = 8'hf0;
    localparam logic [7:0] FCS_CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] FCS_CMD_ERASE = 8'h80;
    localparam logic [7:0] FCS_CMD_PROTECT = 8'h9a;
    localparam logic [7:0] FCS_CMD_VERIFY = 8'h90;
    localparam logic [7:0] FCS_CMD_CHIP = 8'h10;
    localparam logic [7:0] FCS_CMD_BLOCK = 8'h30;
    localparam logic [7:0] FCS_CMD_LOCK = 8'h70;
    localparam logic [7:0] FCS_SEC_KEY = 8'hc9;
    // ------------------------------------------------------------
    // Device registers
    // ------------------------------------------------------------
    localparam logic [15:0] FCS_SEC_OFFSET = 16'h016b;
    localparam logic [15:0] FCS_STATUS_OFFSET = 16'h016e;
    localparam logic [7:0] FCS_SEC_RESET = 8'h00;
    localparam int FCS_RB_BIT = 2;
    // ------------------------------------------------------------
    // Controller registers on AHB-Lite
    // ------------------------------------------------------------
    localparam logic [7:0] FCS_R_ADDR = 8'h00;
    localparam logic [7:0] FCS_R_WDATA = 8'h04;
    localparam logic [7:0] FCS_R_CTRL = 8'h08;
    localparam logic [7:0] FCS_R_RDATA = 8'h0c;
    localparam logic [7:0] FCS_R_STAT = 8'h10;
    localparam int FCS_CTRL_GO = 0;
    localparam int FCS_CTRL_WRITE = 1;
    localparam int FCS_CTRL_WORD = 2;
    localparam int FCS_STAT_BUSY = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int FCS_CLK_MHZ = 100;
    localparam int FCS_GAP_NS = 20;
    localparam int FCS_GAP_CYC = (FCS_GAP_NS * FCS_CLK_MHZ + 999) / 1000;
    localparam int FCS_OP_NS = 1000;
    localparam int FCS_OP_CYC = FCS_OP_NS * FCS_CLK_MHZ / 1000;
    localparam int FCS_BLOCKS = 10;
endpackage

// ===== hw/fcs_link_if.sv
// Interface joining the CPU-side controller and the flash sequencer.
// Assumes one clock; each access is a one-cycle strobe with its read reply registered for the next cycle.
`timescale 1ns/1ps
`default_nettype none
interface fcs_link_if;
    logic stb;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport dev (input stb, we, word, addr, wdata, output rdata);
    modport host (output stb, we, word, addr, wdata, input rdata);
endinterface
`default_nettype wire

// ===== hw/fcs_op_timer.sv
// Down-counter that times one automatic operation.
// Assumes start is a one-cycle pulse; done pulses when the count expires.
`timescale 1ns/1ps
`default_nettype none
module fcs_op_timer #(
    parameter int CYCLES = 100
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Control
    input wire logic start,
    input wire logic abort,
    output logic done
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;

    // Done depends on the count alone, so a caller may restart from done.
    always_comb begin
        next_cnt = cnt;
        done = (cnt == 16'h0001);
        if (abort) begin
            next_cnt = '0;
        end else if (start) begin
            next_cnt = 16'(CYCLES);
        end else if (cnt != '0) begin
            next_cnt = cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
        end else if (ce) begin
            cnt <= next_cnt;
        end
    end
endmodule
`default_nettype wire

// ===== hw/fcs_device.sv
// Flash command sequencer: decodes unlock and command write cycles.
// Assumes the host keeps spacing and byte-wide command writes.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fcs_device
    import fcs_pkg::*;
#(
    parameter int OP_CYCLES = FCS_OP_CYC,
    parameter int BLOCKS = FCS_BLOCKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Link to the controller
    fcs_link_if.dev link,
    // Flash array status
    input wire logic op_fail,
    output logic [2:0] op_phase
);
    typedef enum logic [3:0] {
        FCS_READ, FCS_U1, FCS_U2, FCS_PROG, FCS_E4, FCS_E5, FCS_P4, FCS_P5,
        FCS_VERIFY, FCS_BUSY, FCS_FAILED
    } fcs_state_t;

    typedef enum logic [2:0] {
        FCS_OP_NONE, FCS_OP_PROG, FCS_OP_ERASE, FCS_OP_PROTECT,
        FCS_OP_UNPROT, FCS_OP_WIPE, FCS_OP_BLANK
    } fcs_op_t;

    fcs_state_t state, next_state;
    fcs_op_t op, next_op;
    logic ready_busy_flag, next_ready_busy_flag;
    logic [7:0] chip_erase_security_enable, next_sec;
    logic [BLOCKS-1:0] lock, next_lock;
    logic [3:0] blk, next_blk;
    logic [31:0] rdata, next_rdata;
    logic start, abort, done;
    logic wr, rd;
    logic [7:0] d;
    logic [3:0] blk_of;

    assign wr = link.stb && link.we;
    assign rd = link.stb && !link.we;
    assign d = link.wdata[7:0];
    assign blk_of = 4'(link.addr[15:12] % 4'(BLOCKS));
    assign link.rdata = rdata;
    assign op_phase = op;

    fcs_op_timer #(.CYCLES(OP_CYCLES)) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .start(start),
        .abort(abort),
        .done(done)
    );

    // ------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_op = op;
        next_ready_busy_flag = ready_busy_flag;
        next_sec = chip_erase_security_enable;
        next_lock = lock;
        next_blk = blk;
        start = 1'b0;
        abort = 1'b0;
        if (state == FCS_BUSY) begin
            // Writes fall through unheard here.
            if (done && op_fail) begin
                next_state = FCS_FAILED;
            end else if (done) begin
                unique case (op)
                    FCS_OP_UNPROT: begin
                        next_lock = '0;
                        next_op = FCS_OP_WIPE;
                        start = 1'b1;
                    end
                    FCS_OP_WIPE: begin
                        next_op = FCS_OP_BLANK;
                        start = 1'b1;
                    end
                    FCS_OP_PROTECT: begin
                        next_lock[blk] = 1'b1;
                        next_op = FCS_OP_NONE;
                    end
                    default: begin
                        next_op = FCS_OP_NONE;
                    end
                endcase
                if (op != FCS_OP_UNPROT && op != FCS_OP_WIPE) begin
                    next_state = FCS_READ;
                    next_ready_busy_flag = 1'b1;
                end
            end
        end else if (state == FCS_FAILED) begin
            next_ready_busy_flag = 1'b0;
            if (wr && d == FCS_CMD_RESET && link.addr[7:0] == FCS_RESET_LOW) begin
                next_state = FCS_READ;
                next_op = FCS_OP_NONE;
                next_ready_busy_flag = 1'b1;
            end
        end else if (wr) begin
            next_state = FCS_READ;
            unique case (state)
                FCS_READ, FCS_VERIFY: begin
                    if (link.addr == FCS_UNLOCK1_ADDR && d == FCS_UNLOCK1_DATA) begin
                        next_state = FCS_U1;
                    end else if (state == FCS_VERIFY && !(d == FCS_CMD_RESET
                            && link.addr[7:0] == FCS_RESET_LOW)) begin
                        next_state = FCS_VERIFY;
                    end
                end
                FCS_U1: begin
                    if (link.addr == FCS_UNLOCK2_ADDR && d == FCS_UNLOCK2_DATA) begin
                        next_state = FCS_U2;
                    end
                end
                FCS_U2: begin
                    if (link.addr == FCS_UNLOCK1_ADDR) begin
                        unique case (d)
                            FCS_CMD_PROGRAM: next_state = FCS_PROG;
                            FCS_CMD_ERASE: next_state = FCS_E4;
                            FCS_CMD_PROTECT: next_state = FCS_P4;
                            FCS_CMD_VERIFY: next_state = FCS_VERIFY;
                            default: next_state = FCS_READ;
                        endcase
                    end
                end
                FCS_PROG: begin
                    if (link.word && link.addr == FCS_SEC_OFFSET) begin
                        next_sec = d;
                    end else if (link.word && link.addr[1:0] == 2'b00) begin
                        next_state = FCS_BUSY;
                        next_op = FCS_OP_PROG;
                        next_ready_busy_flag = 1'b0;
                        start = 1'b1;
                    end
                end
                FCS_E4, FCS_P4: begin
                    if (link.addr == FCS_UNLOCK1_ADDR && d == FCS_UNLOCK1_DATA) begin
                        next_state = (state == FCS_E4) ? FCS_E5 : FCS_P5;
                    end
                end
                FCS_E5, FCS_P5: begin
                    if (link.addr == FCS_UNLOCK2_ADDR && d == FCS_UNLOCK2_DATA) begin
                        next_state = (state == FCS_E5) ? FCS_E5 : FCS_P5;
                        next_blk = 4'hf;
                    end
                end
                default: begin
                    next_state = FCS_READ;
                end
            endcase
            // Sixth cycle, entered once the second unlock pair was seen.
            if ((state == FCS_E5 || state == FCS_P5) && blk == 4'hf) begin
                next_state = FCS_READ;
                next_blk = blk_of;
                if (state == FCS_E5 && d == FCS_CMD_CHIP
                        && link.addr == FCS_UNLOCK1_ADDR) begin
                    if (chip_erase_security_enable == FCS_SEC_KEY) begin
                        next_op = FCS_OP_UNPROT;
                    end else begin
                        next_op = FCS_OP_ERASE;
                    end
                    next_state = FCS_BUSY;
                end else if (state == FCS_E5 && d == FCS_CMD_BLOCK) begin
                    next_op = FCS_OP_ERASE;
                    next_state = FCS_BUSY;
                end else if (state == FCS_P5 && d == FCS_CMD_LOCK) begin
                    next_op = FCS_OP_PROTECT;
                    next_state = FCS_BUSY;
                end
                if (next_state == FCS_BUSY) begin
                    next_ready_busy_flag = 1'b0;
                    start = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = rdata;
        if (rd) begin
            next_rdata = '0;
            if (link.addr == FCS_STATUS_OFFSET) begin
                next_rdata[FCS_RB_BIT] = ready_busy_flag;
            end else if (link.addr == FCS_SEC_OFFSET) begin
                next_rdata[7:0] = chip_erase_security_enable;
            end else if (state == FCS_VERIFY && link.addr[6] == 1'b0
                    && link.addr[4:0] == 5'h10) begin
                next_rdata[0] = lock[blk_of];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= FCS_READ;
            op <= FCS_OP_NONE;
            ready_busy_flag <= 1'b1;
            chip_erase_security_enable <= FCS_SEC_RESET;
            lock <= '0;
            blk <= '0;
            rdata <= '0;
        end else if (ce) begin
            state <= next_state;
            op <= next_op;
            ready_busy_flag <= next_ready_busy_flag;
            chip_erase_security_enable <= next_sec;
            lock <= next_lock;
            blk <= next_blk;
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== hw/fcs_host.sv
// CPU-side controller: AHB-Lite slave that issues link accesses on demand.
// Assumes software writes address, data, then the control word to go.
`timescale 1ns/1ps
`default_nettype none
module fcs_host
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link
    fcs_link_if.host link
);
    logic [15:0] addr, next_addr;
    logic [31:0] wdata, next_wdata;
    logic [31:0] rdata, next_rdata;
    logic [2:0] ctrl, next_ctrl;
    logic [7:0] gap, next_gap;
    logic [1:0] pend, next_pend;
    logic ph_w, next_ph_w;
    logic ph_v, next_ph_v;
    logic [7:0] ph_a, next_ph_a;
    logic [31:0] hrd, next_hrd;
    logic go;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrd;
    assign link.addr = addr;
    assign link.wdata = wdata;
    assign link.we = ctrl[FCS_CTRL_WRITE];
    assign link.word = ctrl[FCS_CTRL_WORD];
    assign link.stb = (pend == 2'd1);
    assign go = ph_v && ph_w && ph_a == FCS_R_CTRL && hwdata[FCS_CTRL_GO];

    always_comb begin
        next_ph_v = hsel && htrans[1];
        next_ph_w = hwrite;
        next_ph_a = haddr[7:0];
        next_addr = addr;
        next_wdata = wdata;
        next_ctrl = ctrl;
        next_rdata = rdata;
        next_pend = pend;
        next_gap = (gap != '0) ? gap - 8'h01 : gap;
        next_hrd = '0;
        if (ph_v && ph_w && ph_a == FCS_R_ADDR) next_addr = hwdata[15:0];
        if (ph_v && ph_w && ph_a == FCS_R_WDATA) next_wdata = hwdata;
        // Spacing between link cycles is enforced here.
        if (go && pend == 2'd0) begin
            next_ctrl = hwdata[2:0];
            next_pend = (gap == '0) ? 2'd1 : 2'd3;
        end
        if (pend == 2'd3 && gap == '0) next_pend = 2'd1;
        if (pend == 2'd1) begin
            next_pend = 2'd2;
            next_gap = 8'(FCS_GAP_CYC);
        end
        if (pend == 2'd2) begin
            next_pend = 2'd0;
            next_rdata = link.rdata;
        end
        if (next_ph_v && !hwrite) begin
            unique case (haddr[7:0])
                FCS_R_ADDR: next_hrd = {16'h0000, addr};
                FCS_R_WDATA: next_hrd = wdata;
                FCS_R_CTRL: next_hrd = {29'h0, ctrl};
                FCS_R_RDATA: next_hrd = rdata;
                FCS_R_STAT: next_hrd = {31'h0, pend != 2'd0};
                default: next_hrd = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= '0;
            wdata <= '0;
            rdata <= '0;
            ctrl <= '0;
            gap <= '0;
            pend <= '0;
            ph_w <= 1'b0;
            ph_v <= 1'b0;
            ph_a <= '0;
            hrd <= '0;
        end else if (ce) begin
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
            gap <= next_gap;
            pend <= next_pend;
            ph_w <= next_ph_w;
            ph_v <= next_ph_v;
            ph_a <= next_ph_a;
            hrd <= next_hrd;
        end
    end
endmodule
`default_nettype wire

// ===== verification/fcs_chk.sv
// Checker for the link between the controller and the sequencer.
// Assumes one clock domain and the link wires of fcs_link_if.
`timescale 1ns/1ps
`default_nettype none
module fcs_chk
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link wires
    input wire logic stb,
    input wire logic we,
    input wire logic word,
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic wr;
    logic rd;
    logic fresh;
    logic verify;
    logic rst_cmd;
    logic next_fresh;
    logic next_verify;
    logic next_rst_cmd;
    assign wr = stb && we;
    assign rd = stb && !we;
    // Fresh means no write since reset; the flags track the last write.
    always_comb begin
        next_fresh = fresh && !wr;
        next_verify = verify;
        next_rst_cmd = rst_cmd;
        if (wr) begin
            next_verify = addr == FCS_UNLOCK1_ADDR &&
                wdata[7:0] == FCS_CMD_VERIFY;
            next_rst_cmd = addr[7:0] == FCS_RESET_LOW &&
                wdata[7:0] == FCS_CMD_RESET;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fresh <= 1'b1;
            verify <= 1'b0;
            rst_cmd <= 1'b0;
        end else begin
            fresh <= next_fresh;
            verify <= next_verify;
            rst_cmd <= next_rst_cmd;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence status_rd;
        rd && addr == FCS_STATUS_OFFSET;
    endsequence
    sequence check_rd;
        rd && verify && !addr[6] && addr[4:0] == 5'h10;
    endsequence
    idle_gap_a: assert property (stb |=> (!stb) [*2])
        else $error("link strobes closer than the gap");
    rdata_hold_a: assert property (!rd |=> $stable(rdata))
        else $error("link read data changed without a read");
    reset_ready_a: assert property (status_rd ##0 fresh |=>
        rdata[FCS_RB_BIT]) else $error("ready flag low after reset");
    sec_reset_a: assert property (rd && fresh &&
        addr == FCS_SEC_OFFSET |=> rdata[7:0] == FCS_SEC_RESET)
        else $error("security value wrong after reset");
    check_value_a: assert property (check_rd |=>
        rdata[31:1] == 31'h0) else $error("protect check not 0 or 1");
    byte_cmd_a: assert property (wr && addr == FCS_UNLOCK1_ADDR &&
        wdata[7:0] == FCS_UNLOCK1_DATA |-> !word)
        else $error("command cycle was not byte wide");
    word_align_a: assert property (wr && word &&
        addr != FCS_SEC_OFFSET |-> addr[1:0] == 2'b00)
        else $error("word write to unaligned offset");
    reset_cmd_a: assert property (status_rd ##0 rst_cmd |=>
        rdata[FCS_RB_BIT]) else $error("not ready after reset command");
endmodule
`default_nettype wire

// ===== verification/flash_command_sequencer_tb.sv
// Testbench: controller and sequencer joined by the link interface.
// Assumes the controller register map and zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_tb
    import fcs_pkg::*;
;
    localparam int OPC = 200;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic op_fail = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [2:0] op_phase;
    logic [31:0] v;
    logic [15:0] pa;
    logic [31:0] pd;
    logic f;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int m_ready = 1;
    int m_sec = 0;
    int m_prot[10];
    int pb;
    int qb;
    int t0;
    int dt;
    // ------------------------------------------------------------
    // Design
    // ------------------------------------------------------------
    fcs_link_if i_fcs_link_if ();
    fcs_device #(.OP_CYCLES(OPC)) i_fcs_device (.clk(clk), .rst_b(rst_b),
        .ce(1'b1), .link(i_fcs_link_if), .op_fail(op_fail),
        .op_phase(op_phase));
    fcs_host i_fcs_host (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .link(i_fcs_link_if));
    fcs_chk i_fcs_chk (.clk(clk), .rst_b(rst_b),
        .stb(i_fcs_link_if.stb), .we(i_fcs_link_if.we),
        .word(i_fcs_link_if.word), .addr(i_fcs_link_if.addr),
        .wdata(i_fcs_link_if.wdata), .rdata(i_fcs_link_if.rdata));
    initial begin
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus and link tasks
    // ------------------------------------------------------------
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        // Values read right after an edge are those the slave saw at it.
        do @(posedge clk);
        while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk);
        while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic link(input logic [15:0] a, input logic [31:0] d,
                        input logic [2:0] ctl, output logic [31:0] r);
        logic [31:0] s;
        ahb(1'b1, FCS_R_ADDR, {16'h0, a}, s);
        ahb(1'b1, FCS_R_WDATA, d, s);
        ahb(1'b1, FCS_R_CTRL, {29'h0, ctl}, s);
        repeat (2) @(posedge clk);
        do ahb(1'b0, FCS_R_STAT, 32'h0, s);
        while (s[FCS_STAT_BUSY] !== 1'b0);
        ahb(1'b0, FCS_R_RDATA, 32'h0, r);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        link(a, {24'h0, d}, 3'b011, v);
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(FCS_UNLOCK1_ADDR, FCS_UNLOCK1_DATA);
        wr(FCS_UNLOCK2_ADDR, FCS_UNLOCK2_DATA);
        wr(FCS_UNLOCK1_ADDR, c);
    endtask
    task automatic seq6(input logic [7:0] c, input logic [15:0] a,
                        input logic [7:0] d);
        cmd(c);
        wr(FCS_UNLOCK1_ADDR, FCS_UNLOCK1_DATA);
        wr(FCS_UNLOCK2_ADDR, FCS_UNLOCK2_DATA);
        wr(a, d);
    endtask
    task automatic prog(input logic [15:0] a, input logic [31:0] d);
        cmd(FCS_CMD_PROGRAM);
        link(a, d, 3'b111, v);
    endtask
    task automatic status(output logic b);
        link(FCS_STATUS_OFFSET, 32'h0, 3'b001, v);
        b = v[FCS_RB_BIT];
    endtask
    task automatic wait_ready();
        logic b;
        do status(b);
        while (b !== 1'b1);
        dt = cyc - t0;
    endtask
    // ------------------------------------------------------------
    // Checks and report
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_flag(input logic e, input logic g);
        chk_word({31'h0, e}, {31'h0, g});
    endtask
    task automatic chk_sec();
        link(FCS_SEC_OFFSET, 32'h0, 3'b001, v);
        chk_word(32'(m_sec), {24'h0, v[7:0]});
    endtask
    task automatic prot_all();
        cmd(FCS_CMD_VERIFY);
        for (int b = 0; b < 10; b++) begin
            link({b[3:0], 12'h010}, 32'h0, 3'b101, v);
            chk_word(32'(m_prot[b]), v);
        end
        cmd(FCS_CMD_RESET);
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(37865));
        for (int i = 0; i < 10; i++) m_prot[i] = 0;
        pb = $urandom_range(9);
        qb = (pb + 1) % 10;
        pa = {4'h2, 10'($urandom()), 2'b00};
        pd = $urandom();
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        status(f);
        chk_flag(m_ready[0], f);
        chk_sec();
        prot_all();
        wr(16'h0000, FCS_CMD_RESET);
        status(f);
        chk_flag(m_ready[0], f);
        done("reset");
        prog(pa, pd);
        status(f);
        chk_flag(1'b0, f);
        seq6(FCS_CMD_PROTECT, {qb[3:0], 12'h000}, FCS_CMD_LOCK);
        status(f);
        chk_flag(1'b0, f);
        wait_ready();
        done("program");
        wr(FCS_UNLOCK1_ADDR, FCS_UNLOCK1_DATA);
        wr(FCS_UNLOCK2_ADDR, 8'h54);
        wr(FCS_UNLOCK1_ADDR, FCS_CMD_PROGRAM);
        link(pa, pd, 3'b111, v);
        status(f);
        chk_flag(1'b1, f);
        cmd(FCS_CMD_PROTECT);
        wr(FCS_UNLOCK1_ADDR, FCS_UNLOCK1_DATA);
        wr(FCS_UNLOCK2_ADDR, 8'h00);
        wr({pb[3:0], 12'h000}, FCS_CMD_LOCK);
        done("mismatch");
        seq6(FCS_CMD_PROTECT, {pb[3:0], 12'h000}, FCS_CMD_LOCK);
        status(f);
        chk_flag(1'b0, f);
        wait_ready();
        m_prot[pb] = 1;
        prot_all();
        done("protect");
        seq6(FCS_CMD_ERASE, {qb[3:0], 12'h000}, FCS_CMD_BLOCK);
        wait_ready();
        t0 = cyc;
        seq6(FCS_CMD_ERASE, FCS_UNLOCK1_ADDR, FCS_CMD_CHIP);
        wait_ready();
        chk_flag(1'b1, dt < 2 * OPC);
        prot_all();
        done("erase");
        prog(FCS_SEC_OFFSET, {24'h0, FCS_SEC_KEY});
        wait_ready();
        wr(FCS_SEC_OFFSET, 8'h00);
        m_sec = FCS_SEC_KEY;
        chk_sec();
        t0 = cyc;
        seq6(FCS_CMD_ERASE, FCS_UNLOCK1_ADDR, FCS_CMD_CHIP);
        seq6(FCS_CMD_PROTECT, {qb[3:0], 12'h000}, FCS_CMD_LOCK);
        wait_ready();
        chk_flag(1'b1, dt > 2 * OPC);
        for (int i = 0; i < 10; i++) m_prot[i] = 0;
        seq6(FCS_CMD_PROTECT, {pb[3:0], 12'h000}, FCS_CMD_LOCK);
        wait_ready();
        m_prot[pb] = 1;
        prot_all();
        done("unprotect");
        op_fail <= 1'b1;
        seq6(FCS_CMD_ERASE, FCS_UNLOCK1_ADDR, FCS_CMD_CHIP);
        repeat (4 * OPC) @(posedge clk);
        status(f);
        chk_flag(1'b0, f);
        op_fail <= 1'b0;
        wr(16'h3300, FCS_CMD_RESET);
        status(f);
        chk_flag(1'b1, f);
        prog(FCS_SEC_OFFSET, 32'h0);
        wait_ready();
        m_sec = 0;
        chk_sec();
        done("failure");
        summarize();
    end
endmodule
`default_nettype wire
